// *** include/deqad_map.vh ***
// register offsets, field positions and reset values of the eq/strap/audio bank
`ifndef DEQAD_MAP_VH
`define DEQAD_MAP_VH

// ============================================================
// register offsets
`define DEQAD_OFS_EQ_TEST      8'h35
`define DEQAD_OFS_STRAP        8'h37
`define DEQAD_OFS_AUDIO_DIV    8'h3a
`define DEQAD_OFS_EQUALIZER_SETTING_STATUS    8'h3b

// ============================================================
// equalizer_test_control fields
`define DEQAD_EQT_RESTART      6
`define DEQAD_EQT_FLOOR_OV     5
`define DEQAD_EQT_FLOOR_SET    4
`define DEQAD_EQT_RESET        3'h0

// ============================================================
// strap_decode_status fields
`define DEQAD_STR_BC_DONE      7
`define DEQAD_STR_BC_MSB       6
`define DEQAD_STR_BC_LSB       4
`define DEQAD_STR_OM_DONE      3
`define DEQAD_STR_OM_MSB       2
`define DEQAD_STR_OM_LSB       0

// ============================================================
// audio_clock_divider_select fields
`define DEQAD_AUD_OUT_OV       7
`define DEQAD_AUD_OUT_MSB      6
`define DEQAD_AUD_OUT_LSB      4
`define DEQAD_AUD_IN_OV        2
`define DEQAD_AUD_IN_MSB       1
`define DEQAD_AUD_IN_LSB       0
`define DEQAD_AUD_RESET        7'h00

// ============================================================
// equalizer_setting_status and reset values
`define DEQAD_EQS_RESET        6'h00
`define DEQAD_RD_RESET         8'h00

`endif

// *** core/deqad_strap_latch.v ***
// strap pin synchroniser and one-time decode latch with done flag
`timescale 1ns/1ps
`default_nettype none

module deqad_strap_latch (
    // clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // strap decoder pins (asynchronous)
    input  wire [2:0] strap_code_pin,
    input  wire       strap_ready_pin,
    // latched result
    output reg  [2:0] strap_code,
    output reg        strap_done
);

    // ============================================================
    // two-flop synchroniser
    reg [2:0] code_s1_reg;    // first stage, read only by second
    reg [2:0] code_s2_reg;    // safe copy
    reg       rdy_s1_reg;     // first stage, read only by second
    reg       rdy_s2_reg;     // safe copy

    // sync stages, no logic between them
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            code_s1_reg <= 3'h0;
            code_s2_reg <= 3'h0;
            rdy_s1_reg  <= 1'h0;
            rdy_s2_reg  <= 1'h0;
        end else begin
            code_s1_reg <= strap_code_pin;
            code_s2_reg <= code_s1_reg;
            rdy_s1_reg  <= strap_ready_pin;
            rdy_s2_reg  <= rdy_s1_reg;
        end
    end

    // ============================================================
    // latch once; the code is only taken one cycle after ready is
    // seen so that data and ready cross with the same two stages
    reg       rdy_s3_reg;     // ready delayed, gives code time to settle

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_s3_reg <= 1'h0;
            strap_code <= 3'h0;
            strap_done <= 1'h0;
        end else begin
            rdy_s3_reg <= rdy_s2_reg;
            // done reads zero until the decode sits in the field
            if (rdy_s3_reg && !strap_done) begin
                strap_code <= code_s2_reg;
                strap_done <= 1'h1;
            end
        end
    end

endmodule // deqad_strap_latch

`default_nettype wire

// *** core/deqad_regs.v ***
// equalizer test, strap decode, audio divider and equalizer_setting_status register bank
//
// Notes on behaviour
// - restart bit restarts adaptation on both ports
// - preset floor only acts with override set
// - preset floor starts adaptation above zero
// - port-select set steers test writes to port 1
// - port-select set returns port 1 equalizer_setting_status
// - back-channel done flags latched strap decode
// - back-channel code gives rate and medium
// - output-mode done flags latched mode decode
// - output-mode code gives four repeating modes
// - output divider override selects software ratio
// - output divider field picks 32 down to 1
// - input override clear leaves pll choosing ratio
// - input divider field picks 1,2,4,8
// - status shows manual values when bypassed
// - port-select writes port1 plus shared, reads port1
// - bypass bit disables adaptation, uses manual values
`timescale 1ns/1ps
`default_nettype none
`include "deqad_map.vh"

module deqad_regs (
    // clock and reset
    input  wire       mclk,
    input  wire       sys_rst,
    // register access port from the serial control bus logic
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    // port selection from the receive control register
    input  wire       second_port_select,
    // bypass register contents of each port
    input  wire       p0_adaptation_bypass,
    input  wire [2:0] p0_bypass_stage1,
    input  wire [2:0] p0_bypass_stage2,
    input  wire       p1_adaptation_bypass,
    input  wire [2:0] p1_bypass_stage1,
    input  wire [2:0] p1_bypass_stage2,
    // setting chosen by each adaptive equalizer
    input  wire [5:0] p0_adaptive_setting,
    input  wire [5:0] p1_adaptive_setting,
    // strap decoders (asynchronous pins)
    input  wire [2:0] backchannel_strap_pin,
    input  wire       backchannel_strap_ready,
    input  wire [2:0] output_mode_strap_pin,
    input  wire       output_mode_strap_ready,
    // divider ratios the pll state machine would pick
    input  wire [5:0] pll_out_div_ratio,
    input  wire [3:0] pll_in_div_ratio,
    // equalizer controls to the analog front end
    output reg        p0_equalizer_restart,
    output reg        p1_equalizer_restart,
    output reg        p0_floor_start,
    output reg        p1_floor_start,
    output reg        p0_adaptation_enable,
    output reg        p1_adaptation_enable,
    output reg  [5:0] p0_equalizer_setting,
    output reg  [5:0] p1_equalizer_setting,
    // decoded straps
    output reg        backchannel_rate_20m,
    output reg        backchannel_coax,
    output reg  [1:0] output_mode,
    // audio master clock dividers
    output reg  [5:0] audio_out_div_ratio,
    output reg  [3:0] audio_in_div_ratio
);

    // ============================================================
    // functions
    // eq setting to analog: manual {stage2, stage1} or adaptive
    function [5:0] eq_pick;
        input       bypass;
        input [2:0] stg2;
        input [2:0] stg1;
        input [5:0] adaptive;
        begin
            if (bypass)
                eq_pick = {stg2, stg1};
            else
                eq_pick = adaptive;
        end
    endfunction

    // output divider code to ratio; 10x share ratio 2, 11x share ratio 1
    function [5:0] out_ratio;
        input [2:0] code;
        begin
            case (code)
                3'h0:    out_ratio = 6'h20;
                3'h1:    out_ratio = 6'h10;
                3'h2:    out_ratio = 6'h08;
                3'h3:    out_ratio = 6'h04;
                3'h4:    out_ratio = 6'h02;
                3'h5:    out_ratio = 6'h02;
                default: out_ratio = 6'h01;
            endcase
        end
    endfunction

    // ============================================================
    // stored registers
    reg [2:0] p0_test_reg;    // port 0 {restart, floor ov, floor set}
    reg [2:0] p1_test_reg;    // port 1 {restart, floor ov, floor set}
    reg [6:0] audio_reg;      // {out ov, out sel, in ov, in sel}
    reg [5:0] p0_status_reg;  // port 0 eq setting snapshot
    reg [5:0] p1_status_reg;  // port 1 eq setting snapshot

    // write decode
    wire wr_test  = reg_wr && (reg_addr == `DEQAD_OFS_EQ_TEST);
    wire wr_audio = reg_wr && (reg_addr == `DEQAD_OFS_AUDIO_DIV);

    // test field bits of a write, reserved bits dropped
    wire [2:0] test_wdata = {reg_wdata[`DEQAD_EQT_RESTART],
                             reg_wdata[`DEQAD_EQT_FLOOR_OV],
                             reg_wdata[`DEQAD_EQT_FLOOR_SET]};

    // ============================================================
    // per-port test registers; the port select steers writes
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            p0_test_reg <= `DEQAD_EQT_RESET;
            p1_test_reg <= `DEQAD_EQT_RESET;
        end else if (wr_test) begin
            if (second_port_select)
                p1_test_reg <= test_wdata;
            else
                p0_test_reg <= test_wdata;
        end
    end

    // ============================================================
    // shared audio register, written whatever port is selected
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            audio_reg <= `DEQAD_AUD_RESET;
        end else if (wr_audio) begin
            // bit 3 is reserved and never stored
            audio_reg <= {reg_wdata[`DEQAD_AUD_OUT_OV],
                          reg_wdata[`DEQAD_AUD_OUT_MSB:`DEQAD_AUD_OUT_LSB],
                          reg_wdata[`DEQAD_AUD_IN_OV],
                          reg_wdata[`DEQAD_AUD_IN_MSB:`DEQAD_AUD_IN_LSB]};
        end
    end

    // ============================================================
    // strap latches
    wire [2:0] bc_code;       // latched back-channel decode
    wire       bc_done;       // back-channel decode latched
    wire [2:0] om_code;       // latched output-mode decode
    wire       om_done;       // output-mode decode latched

    deqad_strap_latch u_bc_strap (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .strap_code_pin  (backchannel_strap_pin),
        .strap_ready_pin (backchannel_strap_ready),
        .strap_code      (bc_code),
        .strap_done      (bc_done)
    );

    deqad_strap_latch u_om_strap (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .strap_code_pin  (output_mode_strap_pin),
        .strap_ready_pin (output_mode_strap_ready),
        .strap_code      (om_code),
        .strap_done      (om_done)
    );

    // ============================================================
    // control outputs, all registered
    // restart of either port restarts both; level, not a pulse,
    // so adaptation stays held until software writes zero
    wire restart_any = p0_test_reg[2] | p1_test_reg[2];

    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            p0_equalizer_restart <= 1'h0;
            p1_equalizer_restart <= 1'h0;
            p0_floor_start       <= 1'h0;
            p1_floor_start       <= 1'h0;
            p0_adaptation_enable <= 1'h0;
            p1_adaptation_enable <= 1'h0;
            p0_status_reg        <= `DEQAD_EQS_RESET;
            p1_status_reg        <= `DEQAD_EQS_RESET;
            p0_equalizer_setting <= `DEQAD_EQS_RESET;
            p1_equalizer_setting <= `DEQAD_EQS_RESET;
        end else begin
            p0_equalizer_restart <= restart_any;
            p1_equalizer_restart <= restart_any;
            // floor set ignored unless its override is set
            p0_floor_start <= p0_test_reg[1] & p0_test_reg[0];
            p1_floor_start <= p1_test_reg[1] & p1_test_reg[0];
            p0_adaptation_enable <= ~p0_adaptation_bypass;
            p1_adaptation_enable <= ~p1_adaptation_bypass;
            p0_status_reg <= eq_pick(p0_adaptation_bypass,
                                     p0_bypass_stage2,
                                     p0_bypass_stage1,
                                     p0_adaptive_setting);
            p1_status_reg <= eq_pick(p1_adaptation_bypass,
                                     p1_bypass_stage2,
                                     p1_bypass_stage1,
                                     p1_adaptive_setting);
            p0_equalizer_setting <= eq_pick(p0_adaptation_bypass,
                                            p0_bypass_stage2,
                                            p0_bypass_stage1,
                                            p0_adaptive_setting);
            p1_equalizer_setting <= eq_pick(p1_adaptation_bypass,
                                            p1_bypass_stage2,
                                            p1_bypass_stage1,
                                            p1_adaptive_setting);
        end
    end

    // ============================================================
    // strap decode and divider outputs
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            backchannel_rate_20m <= 1'h0;
            backchannel_coax     <= 1'h0;
            output_mode          <= 2'h0;
            audio_out_div_ratio  <= 6'h20;
            audio_in_div_ratio   <= 4'h1;
        end else begin
            // msb of the back-channel code does not matter
            backchannel_rate_20m <= bc_code[1];
            backchannel_coax     <= bc_code[0];
            // 0 dual, 1 dual swapped, 2 single, 3 replicate
            output_mode          <= om_code[1:0];
            if (audio_reg[6])
                audio_out_div_ratio <= out_ratio(audio_reg[5:3]);
            else
                audio_out_div_ratio <= pll_out_div_ratio;
            if (audio_reg[2])
                audio_in_div_ratio <= 4'h1 << audio_reg[1:0];
            else
                audio_in_div_ratio <= pll_in_div_ratio;
        end
    end

    // ============================================================
    // read mux; reads of per-port registers follow the port select
    reg [7:0] rd_next;        // read data for this address
    reg [2:0] test_rd;        // selected port test bits
    reg [5:0] status_rd;      // selected port status

    always @* begin
        test_rd   = second_port_select ? p1_test_reg : p0_test_reg;
        status_rd = second_port_select ? p1_status_reg
                                       : p0_status_reg;
        case (reg_addr)
            `DEQAD_OFS_EQ_TEST:
                rd_next = {1'h0, test_rd, 4'h0};
            `DEQAD_OFS_STRAP:
                rd_next = {bc_done, bc_code, om_done, om_code};
            `DEQAD_OFS_AUDIO_DIV:
                rd_next = {audio_reg[6:3], 1'h0, audio_reg[2:0]}
                          ;
            `DEQAD_OFS_EQUALIZER_SETTING_STATUS:
                rd_next = {2'h0, status_rd};
            default:
                rd_next = `DEQAD_RD_RESET;   // other registers elsewhere
        endcase
    end

    // answer one cycle after the read strobe
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata  <= `DEQAD_RD_RESET;
            reg_rvalid <= 1'h0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rd_next;
        end
    end

endmodule // deqad_regs

`default_nettype wire

// *** verification/deqad_regs_asserts.sv ***
// concurrent checks on the ports of the eq/strap/audio register bank
`timescale 1ns/1ps
`default_nettype none

module deqad_regs_asserts (
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // register access port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    // port select, bypass and adaptive inputs
    input wire logic       second_port_select,
    input wire logic       p0_adaptation_bypass,
    input wire logic       p1_adaptation_bypass,
    input wire logic [2:0] p1_bypass_stage1,
    input wire logic [2:0] p1_bypass_stage2,
    input wire logic [5:0] p1_adaptive_setting,
    // equalizer controls
    input wire logic       p0_equalizer_restart,
    input wire logic       p1_equalizer_restart,
    input wire logic       p0_floor_start,
    input wire logic       p1_floor_start,
    input wire logic       p0_adaptation_enable,
    input wire logic       p1_adaptation_enable,
    input wire logic [5:0] p1_equalizer_setting
);
    // ============================================================
    // helper logic
    logic [1:0] age_reg;  // edges since reset, saturating at 3
    // writes to the test register, split by port and bit pattern
    wire wr_test = reg_wr & (reg_addr == 8'h35);
    wire fl0 = wr_test & ~second_port_select & reg_wdata[5] & reg_wdata[4];
    wire fl1 = wr_test & second_port_select & reg_wdata[5] & reg_wdata[4];
    wire rs = wr_test & reg_wdata[6];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // age guards $past from seeing values from inside reset
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            age_reg <= 2'h0;
        else if (age_reg != 2'h3)
            age_reg <= age_reg + 2'h1;
    end

    // bits that must read zero for each address; unmapped reads all zero
    function automatic logic [7:0] rsv_mask(input logic [7:0] a);
        case (a)
            8'h35: rsv_mask = 8'h8f;
            8'h37: rsv_mask = 8'h00;
            8'h3a: rsv_mask = 8'h08;
            8'h3b: rsv_mask = 8'hc0;
            default: rsv_mask = 8'hff;
        endcase
    endfunction

    // ============================================================
    // assertions
    a_read_answer:
    assert property (age_reg != 2'h0 |-> reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after the strobe");
    a_rdata_hold:
    assert property (age_reg != 2'h0 && !reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_reserved_zero:
    assert property (age_reg != 2'h0 && reg_rvalid |->
        (reg_rdata & rsv_mask($past(reg_addr))) == 8'h00)
        else $error("reserved or unmapped bits read nonzero");
    a_restart_both:
    assert property (p0_equalizer_restart == p1_equalizer_restart)
        else $error("restart differs between ports");
    a_restart_cause:
    assert property ($rose(p0_equalizer_restart) |-> $past(rs, 2))
        else $error("restart rose without a restart write");
    a_floor_port0:
    assert property ($rose(p0_floor_start) |-> $past(fl0, 2))
        else $error("port0 floor start without override and set");
    a_floor_port1:
    assert property ($rose(p1_floor_start) |-> $past(fl1, 2))
        else $error("port1 floor start without selected write");
    a_adapt_enable:
    assert property (age_reg != 2'h0 |->
        p0_adaptation_enable == !$past(p0_adaptation_bypass) &&
        p1_adaptation_enable == !$past(p1_adaptation_bypass))
        else $error("adaptation enable not inverse of bypass");
    a_setting_p1:
    assert property (age_reg != 2'h0 |-> p1_equalizer_setting ==
        ($past(p1_adaptation_bypass) ?
        {$past(p1_bypass_stage2), $past(p1_bypass_stage1)} :
        $past(p1_adaptive_setting)))
        else $error("port1 equalizer setting wrong source");
endmodule // deqad_regs_asserts

`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the eq/strap/audio register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ============================================================
    // stimulus and observed signals
    logic            mclk, sys_rst, reg_wr, reg_rd, sel, bcr, omr;
    logic [7:0]      reg_addr, reg_wdata, d, r;
    logic [1:0]      byp;
    logic [1:0][2:0] st1, st2;
    logic [1:0][5:0] ada;
    logic [2:0]      bcp, omp, bc, om;
    logic [5:0]      pout;
    logic [3:0]      pin;
    logic [7:0]      treg [2];  // expected test register of each port
    int              i, c, fail_count, cmp_count;
    wire  [7:0]      reg_rdata;
    wire             reg_rvalid, rate20, coax;
    wire  [1:0]      rst_o, fl_o, en_o, om_o;
    wire  [1:0][5:0] set_o;
    wire  [5:0]      aout;
    wire  [3:0]      ain;

    deqad_regs u_deqad_regs (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .second_port_select(sel), .p0_adaptation_bypass(byp[0]),
        .p0_bypass_stage1(st1[0]), .p0_bypass_stage2(st2[0]),
        .p1_adaptation_bypass(byp[1]), .p1_bypass_stage1(st1[1]),
        .p1_bypass_stage2(st2[1]), .p0_adaptive_setting(ada[0]),
        .p1_adaptive_setting(ada[1]), .backchannel_strap_pin(bcp),
        .backchannel_strap_ready(bcr), .output_mode_strap_pin(omp),
        .output_mode_strap_ready(omr), .pll_out_div_ratio(pout),
        .pll_in_div_ratio(pin), .p0_equalizer_restart(rst_o[0]),
        .p1_equalizer_restart(rst_o[1]), .p0_floor_start(fl_o[0]),
        .p1_floor_start(fl_o[1]), .p0_adaptation_enable(en_o[0]),
        .p1_adaptation_enable(en_o[1]), .p0_equalizer_setting(set_o[0]),
        .p1_equalizer_setting(set_o[1]), .backchannel_rate_20m(rate20),
        .backchannel_coax(coax), .output_mode(om_o),
        .audio_out_div_ratio(aout), .audio_in_div_ratio(ain)
    );

    // ============================================================
    // shared tasks; inputs move on the falling edge only
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // write strobe is a one-cycle pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    // bounded wait for the answer; a missing answer ends the run
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        for (int k = 0; k < 4 && reg_rvalid !== 1'b1; k++) @(negedge mclk);
        chk("read answer", reg_rvalid, 8'h01);
        if (reg_rvalid !== 1'b1)
            complete_run();
        v = reg_rdata;
    endtask

    // reset also clears the bench copy of the test registers
    task automatic do_reset();
        sys_rst = 1'b1;
        cyc(10);
        chk("out div reset", aout, 8'h20);
        chk("in div reset", ain, 8'h01);
        sys_rst = 1'b0;
        treg[0] = 8'h00;
        treg[1] = 8'h00;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ============================================================
    // expectation functions
    function automatic logic [5:0] exp_out(input logic [2:0] k);
        exp_out = (k >= 3'h6) ? 6'h01 : (k >= 3'h4) ? 6'h02 : 6'h20 >> k;
    endfunction

    function automatic logic [5:0] exp_eq(input int p);
        exp_eq = byp[p] ? {st2[p], st1[p]} : ada[p];
    endfunction

    // ============================================================
    // clock and main sequence
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        {reg_wr, reg_rd, sel, bcr, omr, byp, st1, st2, ada} = '0;
        {reg_addr, reg_wdata, bcp, omp, pout, pin} = '0;
        fail_count = 0;
        cmp_count = 0;
        void'($urandom(32'h4c71));
        // strap latch is once per reset, so each code gets its own reset
        for (c = 0; c < 8; c++) begin
            bc = c[2:0];
            om = ~c[2:0];
            bcp = bc;
            omp = om;
            {bcr, omr} = 2'b00;
            do_reset();
            cyc(4);
            rd(8'h37, d); chk("strap idle", d, 8'h00);
            rd(8'h35, d); chk("test reset", d, 8'h00);
            rd(8'h3a, d); chk("div reset", d, 8'h00);
            {bcr, omr} = 2'b11;
            cyc(6);
            rd(8'h37, d); chk("strap", d, {1'b1, bc, 1'b1, om});
            chk("bc rate", rate20, bc[1]);
            chk("bc coax", coax, bc[0]);
            chk("out mode", om_o, om[1:0]);
            {bcp, omp} = {~bc, ~om};
            wr(8'h37, 8'hff);
            cyc(6);
            rd(8'h37, d); chk("strap held", d, {1'b1, bc, 1'b1, om});
        end
        $display("test strap done");
        // per-port test register with random port and data
        for (i = 0; i < 24; i++) begin
            sel = 1'($urandom);
            d = (i < 2) ? 8'h70 : 8'($urandom);
            wr(8'h35, d);
            treg[sel] = d & 8'h70;
            cyc(2);
            rd(8'h35, d); chk("test reg", d, treg[sel]);
            chk("floor", fl_o, {treg[1][5] & treg[1][4],
                                treg[0][5] & treg[0][4]});
            chk("restart", rst_o, {2{treg[0][6] | treg[1][6]}});
        end
        $display("test eq control done");
        // audio dividers: every code with and without override
        for (i = 0; i < 16; i++) begin
            sel = 1'($urandom);
            pout = 6'($urandom);
            pin = 4'($urandom);
            d = {i[3], i[2:0], 1'($urandom), ~i[3], i[1:0]};
            wr(8'h3a, d);
            cyc(3);
            rd(8'h3a, r); chk("div reg", r, d & 8'hf7);
            chk("out div", aout, d[7] ? exp_out(d[6:4]) : pout);
            chk("in div", ain, d[2] ? 4'h1 << d[1:0] : pin);
        end
        $display("test audio done");
        // equalizer status from bypass or adaptive source
        for (i = 0; i < 16; i++) begin
            sel = 1'($urandom);
            byp = 2'($urandom);
            {st1, st2, ada} = 24'($urandom);
            wr(8'h3b, 8'($urandom));
            cyc(3);
            rd(8'h3b, r); chk("equalizer_setting_status", r, {2'b00, exp_eq(sel)});
            chk("eq set0", set_o[0], exp_eq(0));
            chk("eq set1", set_o[1], exp_eq(1));
            chk("adapt en", en_o, {6'h00, ~byp});
        end
        wr(8'h36, 8'hff);
        rd(8'h36, r); chk("unmapped", r, 8'h00);
        $display("test equalizer_setting_status done");
        complete_run();
    end
endmodule // tb

bind deqad_regs deqad_regs_asserts u_deqad_regs_asserts (
    .mclk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .second_port_select, .p0_adaptation_bypass,
    .p1_adaptation_bypass, .p1_bypass_stage1, .p1_bypass_stage2,
    .p1_adaptive_setting, .p0_equalizer_restart, .p1_equalizer_restart,
    .p0_floor_start, .p1_floor_start, .p0_adaptation_enable,
    .p1_adaptation_enable, .p1_equalizer_setting
);

`default_nettype wire
